// ---- rtl/scs_pkg.sv ----
// How it works
// - with seven data bits, bit 7 of the transmit byte is never sent
// - outside card operation, one mode bit picks start/stop framing or clocked synchronous transfer
// - parity sense bit: clear gives even parity, set gives odd, both ways
// - parity enable adds parity on async transmit and checks it on receive
// - card operation, guard style clear: transmit done flag 12.5 bit times after start
// - guard style set: transmit done flag 11.0 bit times after start
// - guard style set: clock pin may be held at a fixed level
// - one elementary time unit is the length of one serial bit
// - eight-bit baud divisor, read/write, resets to all ones
// - async outside guard style with both clock source bits clear releases the clock pin
// - synchronous internal clock is driven out on the clock pin
// - async internal clock with low source bit outputs a bit-rate clock
// - synchronous external clock is taken from the clock pin
package scs_pkg;

   // register offsets
   localparam logic [15:0] OFS_MODE   = 16'hff80;
   localparam logic [15:0] OFS_BAUD   = 16'hff81;
   localparam logic [15:0] OFS_CTRL   = 16'hff82;
   localparam logic [15:0] OFS_STATUS = 16'hff83;
   localparam logic [15:0] OFS_MASK   = 16'hff84;
   localparam logic [15:0] OFS_TXBYTE = 16'hff85;
   localparam logic [15:0] OFS_RXBYTE = 16'hff86;
   localparam logic [15:0] OFS_LINK   = 16'hff87;

   // reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'hff;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // status and mask bit positions
   localparam int ST_W       = 3;
   localparam int ST_TX_DONE = 0;
   localparam int ST_RX_FULL = 1;
   localparam int ST_PAR_ERR = 2;

   // frame timing, lengths counted in half bit times, data sizes in bits
   localparam logic [5:0] TRANSMIT_DONE_FLAG_HALF_NORMAL  = 6'd25;
   localparam logic [5:0] TRANSMIT_DONE_FLAG_HALF_GUARD   = 6'd22;
   localparam logic [5:0] SYNC_FRAME_HALVES = 6'd16;
   localparam logic [3:0] DATA_BITS_FULL    = 4'd8;
   localparam logic [3:0] DATA_BITS_SHORT   = 4'd7;
   // 16x external clock: eight rising edges make half a bit
   localparam logic [2:0] EXT_EDGE_LAST     = 3'd7;

   // mode register layout, bit 7 is guard style in card operation
   typedef struct packed {
      logic bit7_sel;
      logic char_length_sel;
      logic parity_on;
      logic parity_odd;
      logic stop_two;
      logic multidrop_on;
      logic prescale_sel_hi;
      logic prescale_sel_lo;
   } scs_mode_t;

   // control register layout
   typedef struct packed {
      logic tx_empty_irq_on;
      logic rx_full_irq_on;
      logic transmitter_on;
      logic receiver_on;
      logic multidrop_irq_on;
      logic tx_done_irq_on;
      logic clock_source_hi;
      logic clock_source_lo;
   } scs_ctrl_t;

   // register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } scs_bus_req_t;

endpackage

// ---- rtl/scs_half_tick.sv ----
`timescale 1ns/100ps
module scs_half_tick (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // timing control
   input  wire logic        restart,
   input  wire logic        ext_sel,
   input  wire logic        sync_mode,
   input  wire logic [14:0] half_len,
   // clock pin input, asynchronous
   input  wire logic        sck_pin_in,
   // one pulse per half bit time
   output logic             half_tick
);
   import scs_pkg::*;

   logic        sck_meta;
   logic        sck_sync;
   logic        sck_prev;
   logic [14:0] cnt;
   logic [14:0] next_cnt;
   logic [2:0]  edges;
   logic [2:0]  next_edges;
   logic        next_tick;
   logic        rise;
   logic        fall;

   // half bit pacing from divider or external clock edges
   always_comb begin
      rise       = sck_sync & ~sck_prev;
      fall       = ~sck_sync & sck_prev;
      next_cnt   = cnt;
      next_edges = edges;
      next_tick  = 1'b0;
      if (restart) begin
         next_cnt   = 15'h0000;
         next_edges = 3'h0;
      end else if (ext_sel) begin
         if (sync_mode) begin
            next_tick = rise | fall;
         end else if (rise) begin
            if (edges == EXT_EDGE_LAST) begin
               next_edges = 3'h0;
               next_tick  = 1'b1;
            end else begin
               next_edges = edges + 3'h1;
            end
         end
      end else if (cnt >= half_len - 15'h0001) begin
         next_cnt  = 15'h0000;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + 15'h0001;
      end
   end

   // pin passes two flops before the edge detector reads it
   always_ff @(posedge clk) begin
      if (rst) begin
         sck_meta  <= 1'b0;
         sck_sync  <= 1'b0;
         sck_prev  <= 1'b0;
         cnt       <= 15'h0000;
         edges     <= 3'h0;
         half_tick <= 1'b0;
      end else begin
         sck_meta  <= sck_pin_in;
         sck_sync  <= sck_meta;
         sck_prev  <= sck_sync;
         cnt       <= next_cnt;
         edges     <= next_edges;
         half_tick <= next_tick;
      end
   end

endmodule

// ---- rtl/scs_serial_card.sv ----
`timescale 1ns/100ps
module scs_serial_card (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // register port
   input  wire scs_pkg::scs_bus_req_t bus_req,
   output logic [7:0]                 rdata,
   output logic                       irq,
   // serial data line
   output logic                       txd,
   input  wire logic                  rxd,
   // clock pin as input, output and enable
   input  wire logic                  sck_in,
   output logic                       sck_out,
   output logic                       sck_oe,
   output logic                       sck_io_port
);
   import scs_pkg::*;

   typedef enum {TX_IDLE, TX_RUN} scs_tx_state_t;
   typedef enum {RX_IDLE, RX_BITS, RX_WAIT} scs_rx_state_t;

   scs_mode_t     mode;
   scs_mode_t     next_mode;
   scs_ctrl_t     ctrl;
   scs_ctrl_t     next_ctrl;
   logic [7:0]    baud;
   logic [7:0]    next_baud;
   logic [7:0]    tx_hold;
   logic [7:0]    next_tx_hold;
   logic          card_en;
   logic          next_card_en;
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] next_status;
   logic [ST_W-1:0] mask;
   logic [ST_W-1:0] next_mask;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;
   logic [7:0]    next_rdata;
   logic          next_irq;
   logic          sync_mode;
   logic          guard;
   logic          ext_sel;
   logic [14:0]   half_len;
   logic          tx_tick;
   logic          rx_tick;
   scs_tx_state_t tx_state;
   scs_tx_state_t next_tx_state;
   logic [5:0]    tx_half;
   logic [5:0]    next_tx_half;
   logic [7:0]    tx_data;
   logic [7:0]    next_tx_data;
   logic          tx_start;
   logic          tx_done_set;
   logic [5:0]    transmit_done_flag_half;
   logic [5:0]    end_half;
   logic          next_txd;
   logic          bitclk;
   logic          next_bitclk;
   logic          next_sck_out;
   logic          next_sck_oe;
   logic          next_sck_io_port;
   logic          rxd_meta;
   logic          rxd_s;
   scs_rx_state_t rx_state;
   scs_rx_state_t next_rx_state;
   logic [5:0]    rx_half;
   logic [5:0]    next_rx_half;
   logic [7:0]    rx_sr;
   logic [7:0]    next_rx_sr;
   logic [7:0]    rx_byte;
   logic [7:0]    next_rx_byte;
   logic [5:0]    rx_h;
   logic [4:0]    rx_idx;
   logic [4:0]    rx_nd;
   logic [4:0]    rx_last;
   logic          rx_full_set;
   logic          par_err_set;

   // data bits per character
   function automatic logic [3:0] data_bits(input scs_mode_t m,
                                            input logic      sync);
      if (!sync && m.char_length_sel)
         data_bits = DATA_BITS_SHORT;
      else
         data_bits = DATA_BITS_FULL;
   endfunction

   // parity over the bits actually sent
   function automatic logic parity_of(input logic [7:0] d,
                                      input scs_mode_t  m);
      logic [7:0] used;
      used = m.char_length_sel ? {1'b0, d[6:0]} : d;
      parity_of = (^used) ^ m.parity_odd;
   endfunction

   // frame length in half bit times
   function automatic logic [5:0] frame_halves(input scs_mode_t m,
                                               input logic      sync);
      logic [5:0] bits;
      bits = 6'd1 + 6'(data_bits(m, sync)) + 6'(m.parity_on)
             + (m.stop_two ? 6'd2 : 6'd1);
      frame_halves = sync ? SYNC_FRAME_HALVES : {bits[4:0], 1'b0};
   endfunction

   // line level for bit position idx of a frame
   function automatic logic frame_bit(input logic [4:0] idx,
                                      input logic [7:0] d,
                                      input scs_mode_t  m,
                                      input logic       sync);
      logic [4:0] nd;
      nd = 5'(data_bits(m, sync));
      if (sync)
         frame_bit = (idx < 5'd8) ? d[idx[2:0]] : 1'b1;
      else if (idx == 5'd0)
         frame_bit = 1'b0;
      else if (idx <= nd)
         frame_bit = d[3'(idx - 5'd1)];
      else if (m.parity_on && idx == nd + 5'd1)
         frame_bit = parity_of(d, m);
      else
         frame_bit = 1'b1;
   endfunction

   // mode decode and half bit time length
   always_comb begin
      sync_mode = ~card_en & mode.bit7_sel;
      guard     = card_en & mode.bit7_sel;
      ext_sel   = ctrl.clock_source_hi & ~guard;
      half_len  = 15'({7'h00, baud} + 15'h0001)
                  << {mode.prescale_sel_hi, mode.prescale_sel_lo, 1'b0};
   end

   // separate pacing so the receiver can align to each start bit
   scs_half_tick u_tx_tick (
      .clk        (clk),
      .rst        (rst),
      .restart    (tx_start),
      .ext_sel    (ext_sel),
      .sync_mode  (sync_mode),
      .half_len   (half_len),
      .sck_pin_in (sck_in),
      .half_tick  (tx_tick)
   );

   scs_half_tick u_rx_tick (
      .clk        (clk),
      .rst        (rst),
      .restart    (rx_state == RX_IDLE),
      .ext_sel    (ext_sel),
      .sync_mode  (sync_mode),
      .half_len   (half_len),
      .sck_pin_in (sck_in),
      .half_tick  (rx_tick)
   );

   // register writes, status with set winning over clear
   always_comb begin
      next_mode    = mode;
      next_baud    = baud;
      next_ctrl    = ctrl;
      next_mask    = mask;
      next_tx_hold = tx_hold;
      next_card_en = card_en;
      st_clr       = '0;
      if (bus_req.wr) begin
         case (bus_req.addr)
            OFS_MODE:   next_mode    = scs_mode_t'(bus_req.wdata);
            OFS_BAUD:   next_baud    = bus_req.wdata;
            OFS_CTRL:   next_ctrl    = scs_ctrl_t'(bus_req.wdata);
            OFS_STATUS: st_clr       = bus_req.wdata[ST_W-1:0];
            OFS_MASK:   next_mask    = bus_req.wdata[ST_W-1:0];
            OFS_TXBYTE: next_tx_hold = bus_req.wdata;
            OFS_LINK:   next_card_en = bus_req.wdata[0];
            default:    next_card_en = card_en;
         endcase
      end
      st_set             = '0;
      st_set[ST_TX_DONE] = tx_done_set;
      st_set[ST_RX_FULL] = rx_full_set;
      st_set[ST_PAR_ERR] = par_err_set;
      next_status        = (status & ~st_clr) | st_set;
      next_irq           = |(next_status & next_mask);
   end

   // read data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            OFS_MODE:   next_rdata = mode;
            OFS_BAUD:   next_rdata = baud;
            OFS_CTRL:   next_rdata = ctrl;
            OFS_STATUS: next_rdata = 8'(status);
            OFS_MASK:   next_rdata = 8'(mask);
            OFS_TXBYTE: next_rdata = tx_hold;
            OFS_RXBYTE: next_rdata = rx_byte;
            OFS_LINK:   next_rdata = {7'h00, card_en};
            default:    next_rdata = 8'h00;
         endcase
      end
   end

   // transmit engine; mode changes mid-frame are the caller's hazard
   always_comb begin
      tx_start      = bus_req.wr && bus_req.addr == OFS_TXBYTE
                      && ctrl.transmitter_on && tx_state == TX_IDLE;
      next_tx_state = tx_state;
      next_tx_half  = tx_half;
      next_tx_data  = tx_data;
      tx_done_set   = 1'b0;
      next_bitclk   = tx_tick ? ~bitclk : bitclk;
      transmit_done_flag_half     = frame_halves(mode, sync_mode);
      if (card_en)
         transmit_done_flag_half = guard ? TRANSMIT_DONE_FLAG_HALF_GUARD : TRANSMIT_DONE_FLAG_HALF_NORMAL;
      end_half = frame_halves(mode, sync_mode);
      if (transmit_done_flag_half > end_half)
         end_half = transmit_done_flag_half;
      case (tx_state)
         TX_IDLE: if (tx_start) begin
            next_tx_state = TX_RUN;
            next_tx_half  = 6'd0;
            next_tx_data  = bus_req.wdata;
         end
         TX_RUN: if (tx_tick) begin
            next_tx_half = tx_half + 6'd1;
            tx_done_set  = (next_tx_half == transmit_done_flag_half);
            if (next_tx_half == end_half)
               next_tx_state = TX_IDLE;
         end
         default: next_tx_state = TX_IDLE;
      endcase
      next_txd = 1'b1;
      if (next_tx_state == TX_RUN)
         next_txd = frame_bit(next_tx_half[5:1], next_tx_data, mode,
                              sync_mode);
   end

   // clock pin role
   always_comb begin
      next_sck_out     = 1'b1;
      next_sck_oe      = 1'b0;
      next_sck_io_port = 1'b0;
      if (guard && !ctrl.clock_source_lo) begin
         next_sck_oe  = 1'b1;
         next_sck_out = ctrl.clock_source_hi;
      end else if (ext_sel) begin
         next_sck_oe = 1'b0;
      end else if (sync_mode) begin
         next_sck_oe  = 1'b1;
         next_sck_out = (tx_state == TX_RUN) ? tx_half[0] : 1'b1;
      end else if (ctrl.clock_source_lo) begin
         next_sck_oe  = 1'b1;
         next_sck_out = bitclk;
      end else begin
         next_sck_io_port = 1'b1;
      end
   end

   // async receiver, samples at the middle of each bit
   always_comb begin
      next_rx_state = rx_state;
      next_rx_half  = rx_half;
      next_rx_sr    = rx_sr;
      next_rx_byte  = rx_byte;
      rx_full_set   = 1'b0;
      par_err_set   = 1'b0;
      rx_h          = rx_half + 6'd1;
      rx_idx        = rx_h[5:1];
      rx_nd         = 5'(data_bits(mode, 1'b0));
      rx_last       = rx_nd + 5'(mode.parity_on);
      case (rx_state)
         RX_IDLE: if (ctrl.receiver_on && !sync_mode && !rxd_s) begin
            next_rx_state = RX_BITS;
            next_rx_half  = 6'd0;
            next_rx_sr    = 8'h00;
         end
         RX_BITS: if (!ctrl.receiver_on) begin
            next_rx_state = RX_IDLE;
         end else if (rx_tick) begin
            next_rx_half = rx_h;
            if (rx_h[0]) begin
               if (rx_idx == 5'd0) begin
                  if (rxd_s)
                     next_rx_state = RX_IDLE; // glitch, not a start bit
               end else if (rx_idx <= rx_nd) begin
                  next_rx_sr[3'(rx_idx - 5'd1)] = rxd_s;
               end
               if (rx_idx != 5'd0 && rx_idx == rx_last) begin
                  next_rx_state = RX_WAIT;
                  next_rx_byte  = next_rx_sr;
                  rx_full_set   = 1'b1;
                  par_err_set   = mode.parity_on
                     && rxd_s != parity_of(next_rx_sr, mode);
               end
            end
         end
         RX_WAIT: if (rxd_s)
            next_rx_state = RX_IDLE;
         default: next_rx_state = RX_IDLE;
      endcase
   end

   // all state registers except those of the checks
   always_ff @(posedge clk) begin
      if (rst) begin
         mode        <= scs_mode_t'(MODE_RST);
         baud        <= BAUD_RST;
         ctrl        <= scs_ctrl_t'(CTRL_RST);
         mask        <= '0;
         status      <= '0;
         tx_hold     <= BYTE_RST;
         card_en     <= 1'b0;
         rdata       <= 8'h00;
         irq         <= 1'b0;
         tx_state    <= TX_IDLE;
         tx_half     <= 6'd0;
         tx_data     <= BYTE_RST;
         txd         <= 1'b1;
         bitclk      <= 1'b0;
         sck_out     <= 1'b1;
         sck_oe      <= 1'b0;
         sck_io_port <= 1'b1;
         rxd_meta    <= 1'b1;
         rxd_s       <= 1'b1;
         rx_state    <= RX_IDLE;
         rx_half     <= 6'd0;
         rx_sr       <= BYTE_RST;
         rx_byte     <= BYTE_RST;
      end else begin
         mode        <= next_mode;
         baud        <= next_baud;
         ctrl        <= next_ctrl;
         mask        <= next_mask;
         status      <= next_status;
         tx_hold     <= next_tx_hold;
         card_en     <= next_card_en;
         rdata       <= next_rdata;
         irq         <= next_irq;
         tx_state    <= next_tx_state;
         tx_half     <= next_tx_half;
         tx_data     <= next_tx_data;
         txd         <= next_txd;
         bitclk      <= next_bitclk;
         sck_out     <= next_sck_out;
         sck_oe      <= next_sck_oe;
         sck_io_port <= next_sck_io_port;
         rxd_meta    <= rxd;
         rxd_s       <= rxd_meta;
         rx_state    <= next_rx_state;
         rx_half     <= next_rx_half;
         rx_sr       <= next_rx_sr;
         rx_byte     <= next_rx_byte;
      end
   end

   // checks
   default clocking dflt @(posedge clk); endclocking
   default disable iff (rst);

   logic [15:0] tick_gap;
   logic        gap_valid;
   logic [14:0] half_len_hold;
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_gap  <= 16'h0000;
         gap_valid <= 1'b0;
      end else begin
         tick_gap  <= tx_tick ? 16'h0001 : tick_gap + 16'h0001;
         gap_valid <= (tx_tick | gap_valid) & ~tx_start & ~ext_sel
                      & (half_len == half_len_hold);
      end
   end
   // divisor of last cycle: a tick launched before a write still uses it
   always_ff @(posedge clk) begin
      half_len_hold <= half_len;
   end

   sequence s_fixed_req;
      (guard && !ctrl.clock_source_lo && $stable(ctrl)) [*2];
   endsequence
   sequence s_port_req;
      (!sync_mode && !guard && !ctrl.clock_source_hi
       && !ctrl.clock_source_lo) [*2];
   endsequence
   sequence s_bitclk_req;
      (!sync_mode && !guard && !ext_sel && ctrl.clock_source_lo) [*2];
   endsequence

   a_start_bit_low: assert property (tx_start && !sync_mode |=> !txd)
      else $error("async frame did not open with a low start bit");
   a_sync_first_bit: assert property (tx_start && sync_mode |=> txd == tx_data[0])
      else $error("sync frame did not open with data bit 0");
   a_seven_bit_msb: assert property (tx_state == TX_RUN && !sync_mode && mode.char_length_sel && !mode.parity_on && tx_half[5:1] == 5'd8 |-> txd)
      else $error("bit 7 sent in seven-bit frame");
   a_parity_bit: assert property (tx_state == TX_RUN && !sync_mode && mode.parity_on && tx_half[5:1] == 5'(data_bits(mode, 1'b0)) + 5'd1 |-> txd == parity_of(tx_data, mode))
      else $error("wrong parity bit on line");
   a_transmit_done_flag_guard: assert property ($rose(status[ST_TX_DONE]) && $past(tx_state) == TX_RUN && guard |-> tx_half == 6'd22)
      else $error("done flag not at 11.0 bit times");
   a_transmit_done_flag_normal: assert property ($rose(status[ST_TX_DONE]) && $past(tx_state) == TX_RUN && card_en && !guard |-> tx_half == 6'd25)
      else $error("done flag not at 12.5 bit times");
   a_half_tick_gap: assert property (tx_tick && gap_valid |-> tick_gap == 16'(half_len_hold))
      else $error("half bit time does not match baud divisor");
   a_fixed_level: assert property (s_fixed_req |-> sck_oe && sck_out == ctrl.clock_source_hi)
      else $error("clock pin not held at fixed level");
   a_pin_release: assert property (s_port_req |-> !sck_oe && sck_io_port)
      else $error("clock pin not released to port use");
   a_sync_clk_out: assert property (sync_mode && !ext_sel |=> sck_oe)
      else $error("sync internal clock not driven out");
   a_bitrate_clk: assert property (s_bitclk_req |-> sck_oe && sck_out == $past(bitclk))
      else $error("bit rate clock not on pin");
   a_bitclk_pace: assert property ($changed(bitclk) |-> $past(tx_tick))
      else $error("bit rate clock moved without a tick");
   a_ext_input: assert property (ext_sel |=> !sck_oe)
      else $error("clock pin driven while external clock selected");
   a_baud_reset: assert property ($fell(rst) |-> baud == 8'hff)
      else $error("baud divisor not all ones after reset");
   a_baud_read: assert property (bus_req.rd && bus_req.addr == OFS_BAUD |=> rdata == $past(baud))
      else $error("baud divisor read back wrong");
   a_flag_set_wins: assert property (tx_done_set |=> status[ST_TX_DONE])
      else $error("done event lost");

endmodule

// ---- bench/scs_card_peer.sv ----
`timescale 1ns/100ps
// card side: sends one character with its own 16x bit clock
module scs_card_peer (
   // serial data and clock toward the port
   output logic rxd,
   output logic sck
);
   // line idles high, clock stands low outside frames
   initial begin
      rxd = 1'b1;
      sck = 1'b0;
   end
   // even parity unless bad flips it, two stop bits
   task automatic send(input logic [7:0] d, input logic bad);
      logic [11:0] f;
      f = {2'b11, ^d ^ bad, d, 1'b0};
      for (int i = 0; i < 12; i++) begin
         rxd = f[i];
         repeat (16) begin
            sck = 1'b1;
            #80 sck = 1'b0;
            #80;
         end
      end
      rxd = 1'b1;
   endtask
endmodule

// ---- bench/scs_serial_card_test.sv ----
`timescale 1ns/100ps
module scs_serial_card_test;
   import scs_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   scs_bus_req_t req = '0;
   logic [7:0]   rdata;
   logic         irq, txd, rxd, sck, sck_out, sck_oe, sck_io_port;
   int           err_count = 0;
   int           samples_checked = 0;
   // pin level: port drives when enabled, else the card side
   wire          sck_pin = sck_oe ? sck_out : sck;

   // 100 MHz clock
   always #5 clk = ~clk;

   scs_serial_card scs_serial_card_inst (.clk(clk), .rst(rst),
      .bus_req(req), .rdata(rdata), .irq(irq), .txd(txd), .rxd(rxd),
      .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe),
      .sck_io_port(sck_io_port));
   scs_card_peer scs_card_peer_inst (.rxd(rxd), .sck(sck));

   task automatic chk(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // one-cycle strobes, released on the next edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask
   // bit time is 4 clocks with divisor 1: sample 1.5 clocks into each bit
   task automatic grab(input int n, output logic [15:0] v);
      int i;
      v = '0;
      i = 0;
      @(negedge clk);
      while (txd !== 1'b0 && i < 200) begin
         @(negedge clk);
         i++;
      end
      repeat (2) @(negedge clk);
      for (i = 0; i < n; i++) begin
         repeat (4) @(negedge clk);
         v[i] = txd;
      end
   endtask
   task automatic done_at(input logic [7:0] m, output int n);
      wr(OFS_MODE, m);
      wr(OFS_STATUS, 8'h07);
      wr(OFS_TXBYTE, 8'h55);
      n = 0;
      while (irq !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      repeat (80) @(posedge clk);
   endtask

   task automatic t_regs;
      rd(OFS_MODE, 8'h00);
      rd(OFS_BAUD, 8'hff);
      rd(OFS_CTRL, 8'h00);
      rd(16'hff90, 8'h00);
      wr(OFS_BAUD, 8'h5a);
      rd(OFS_BAUD, 8'h5a);
      wr(OFS_BAUD, 8'h01);
   endtask
   task automatic t_tx;
      logic [15:0] v;
      wr(16'hff87, 8'h01);
      wr(OFS_CTRL, 8'h20);
      for (int p = 0; p < 2; p++) begin
         wr(OFS_MODE, 8'h28 | 8'(p << 4));
         wr(OFS_TXBYTE, 8'h6b);
         grab(9, v);
         chk("tx frame", {7'h00, 1'(p == 0), 8'h6b}, v);
         repeat (60) @(posedge clk);
      end
      wr(16'hff87, 8'h00);
      wr(OFS_MODE, 8'h40);
      wr(OFS_TXBYTE, 8'h7f);
      grab(8, v);
      chk("seven bit frame", 16'h00ff, v);
      repeat (60) @(posedge clk);
      // clocked frame: no start bit, low bit 0 leads, so grab skips it
      wr(OFS_MODE, 8'h80);
      wr(OFS_TXBYTE, 8'hb4);
      grab(7, v);
      chk("sync frame", 16'h005a, v);
      chk("sync clock oe", 16'h0001, {15'h0000, sck_oe});
      repeat (60) @(posedge clk);
   endtask
   task automatic t_done;
      int n0, n1, n2;
      wr(16'hff87, 8'h01);
      wr(OFS_MASK, 8'h01);
      done_at(8'h28, n0);
      done_at(8'ha8, n1);
      chk("done gap", 16'h0006, 16'(n0 - n1));
      // prescale 1: half bit grows from 2 to 8 clocks, 25 halves later
      done_at(8'h29, n2);
      chk("prescale gap", 16'h0096, 16'(n2 - n0));
      rd(OFS_STATUS, 8'h01);
      wr(OFS_MASK, 8'h00);
      repeat (2) @(negedge clk);
      chk("masked irq", 16'h0000, {15'h0000, irq});
      wr(OFS_MASK, 8'h01);
      wr(OFS_STATUS, 8'h01);
      repeat (2) @(negedge clk);
      chk("cleared irq", 16'h0000, {15'h0000, irq});
   endtask
   // {mode, ctrl, card on, oe/port/level}
   task automatic t_pin;
      logic [23:0] tab [6] = '{24'h00_0004, 24'h00_0108,
         24'h80_0008, 24'h80_0200, 24'ha8_021a, 24'ha8_0018};
      for (int i = 0; i < 6; i++) begin
         wr(16'hff87, {4'h0, tab[i][7:4]});
         wr(OFS_MODE, tab[i][23:16]);
         wr(OFS_CTRL, tab[i][15:8]);
         repeat (4) @(negedge clk);
         chk("pin role", {14'h0000, tab[i][3:2]}, {14'h0000, sck_oe, sck_io_port});
         if (tab[i][4]) chk("pin level", {15'h0000, tab[i][1]}, {15'h0000, sck_out});
      end
   endtask
   task automatic t_rx;
      wr(OFS_MODE, 8'h28);
      wr(OFS_CTRL, 8'h12);
      for (int b = 0; b < 2; b++) begin
         wr(OFS_STATUS, 8'h07);
         // card edges land between our sampling edges
         @(negedge clk);
         scs_card_peer_inst.send(8'ha5, 1'(b));
         repeat (20) @(posedge clk);
         rd(OFS_RXBYTE, 8'ha5);
         rd(OFS_STATUS, b == 1 ? 8'h06 : 8'h02);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_tx;
      t_done;
      t_pin;
      t_rx;
      tally_and_finish;
   end
   // watchdog, about five times the expected run
   initial begin
      #400000;
      err_count++;
      tally_and_finish;
   end
endmodule
